// ===== design/sgp_axil.sv
// AXI4-Lite slave front end for the port registers.
// Assumes the core answers decode and read data in the same cycle.
`timescale 1ns/10ps
module sgp_axil (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output sgp_pkg::sgp_req_s req,
   input wire sgp_pkg::sgp_rsp_s rsp
);
   logic awready_q, wready_q, arready_q, bvalid_q, rvalid_q;
   logic aw_full_q, w_full_q, ar_full_q;
   logic [7:0] waddr_q, raddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;

   assign req.wr = aw_full_q & w_full_q & ~bvalid_q;
   assign req.waddr = waddr_q;
   assign req.wdata = wdata_q;
   assign req.wstrb = wstrb_q;
   assign req.rd = ar_full_q & ~rvalid_q;
   assign req.raddr = raddr_q;
   assign awready = awready_q;
   assign wready = wready_q;
   assign arready = arready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // Write address and write data are taken in either order and held.
   always_ff @(posedge clk) begin
      if (rst) begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b0;
         waddr_q <= 8'h00;
      end else if (awready_q & awvalid) begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b1;
         waddr_q <= awaddr;
      end else if (req.wr) begin
         aw_full_q <= 1'b0;
      end else if (~aw_full_q & ~bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wready_q <= 1'b0;
         w_full_q <= 1'b0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else if (wready_q & wvalid) begin
         wready_q <= 1'b0;
         w_full_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (req.wr) begin
         w_full_q <= 1'b0;
      end else if (~w_full_q & ~bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= sgp_pkg::RESP_OKAY;
      end else if (req.wr) begin
         bvalid_q <= 1'b1;
         bresp_q <= rsp.wr_ok ? sgp_pkg::RESP_OKAY : sgp_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         arready_q <= 1'b0;
         ar_full_q <= 1'b0;
         raddr_q <= 8'h00;
      end else if (arready_q & arvalid) begin
         arready_q <= 1'b0;
         ar_full_q <= 1'b1;
         raddr_q <= araddr;
      end else if (req.rd) begin
         ar_full_q <= 1'b0;
      end else if (~ar_full_q & ~rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= sgp_pkg::RESP_OKAY;
      end else if (req.rd) begin
         rvalid_q <= 1'b1;
         rdata_q <= rsp.rdata;
         rresp_q <= rsp.rd_ok ? sgp_pkg::RESP_OKAY : sgp_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule : sgp_axil

// ===== design/sgp_pkg.sv
// Constants, offsets and types shared by the six-pin port block.
// Assumes a 32-bit AXI4-Lite bus with byte addresses on one clock.
package sgp_pkg;
   localparam int NPIN = 6;
   localparam int AW = 8;
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_DIR = 8'h04;
   localparam logic [7:0] OFS_ANALOG_SELECT = 8'h08;
   localparam logic [7:0] OFS_PULL = 8'h0C;
   localparam logic [7:0] OFS_CHGEN = 8'h10;
   localparam logic [7:0] OFS_OPT = 8'h14;
   localparam logic [7:0] OFS_INTC = 8'h18;
   localparam logic [7:0] OFS_CFG = 8'h1C;
   localparam logic [7:0] OFS_DSET = 8'h20;
   localparam logic [7:0] OFS_DCLR = 8'h24;
   localparam logic [5:0] DIR_RST = 6'h3F;
   localparam logic [5:0] DIR_FIXED = 6'h08;
   localparam logic [5:0] PULL_RST = 6'h37;
   localparam logic [5:0] PULL_MASK = 6'h37;
   localparam logic [5:0] CHGEN_RST = 6'h00;
   localparam logic [5:0] LATCH_RST = 6'h00;
   localparam logic [6:0] ANALOG_SELECT_RST_FULL = 7'h0F;
   localparam logic [6:0] ANALOG_SELECT_RST_SMALL = 7'h0B;
   localparam logic [6:0] ANALOG_SELECT_MASK_FULL = 7'h7F;
   localparam logic [6:0] ANALOG_SELECT_MASK_SMALL = 7'h0B;
   localparam logic [5:0] XTAL_PINS = 6'h30;
   localparam logic [5:0] MASTER_CLEAR_PIN = 6'h08;
   localparam int ADCS_LSB = 4;
   localparam int OPT_GPULL_BIT = 7;
   localparam int INTC_GIE_BIT = 7;
   localparam int INTC_FLAG_BIT = 0;
   localparam int CFG_MASTER_CLEAR_ENABLE_BIT = 0;
   localparam int CFG_OSC_LSB = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      SGP_OSC_OTHER, SGP_OSC_LP, SGP_OSC_XT, SGP_OSC_HS
   } sgp_osc_e;
   typedef enum logic [2:0] {
      SGP_ADC_DIV2, SGP_ADC_DIV4, SGP_ADC_DIV8, SGP_ADC_DIV16,
      SGP_ADC_DIV32, SGP_ADC_DIV64, SGP_ADC_RC
   } sgp_adcclk_e;
   typedef struct packed {
      logic wr;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic rd;
      logic [7:0] raddr;
   } sgp_req_s;
   typedef struct packed {
      logic [31:0] rdata;
      logic rd_ok;
      logic wr_ok;
   } sgp_rsp_s;
endpackage : sgp_pkg

// ===== design/sgp_port.sv
// Six-pin general purpose port with pull-ups and change detection.
// Assumes pins are resolved outside from PIN_O, PIN_OE and PIN_PU.
`timescale 1ns/10ps
module sgp_port #(
   parameter bit FULL_ANALOG_SELECT = 1'b1
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PWR_ON_RST,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic [5:0] PIN_I,
   output logic [5:0] PIN_O,
   output logic [5:0] PIN_OE,
   output logic [5:0] PIN_PU,
   output logic INT_REQ,
   output logic WAKE,
   output sgp_pkg::sgp_adcclk_e ADC_CLK
);
   localparam logic [6:0] ANALOG_SELECT_MASK =
      FULL_ANALOG_SELECT ? sgp_pkg::ANALOG_SELECT_MASK_FULL : sgp_pkg::ANALOG_SELECT_MASK_SMALL;
   localparam logic [6:0] ANALOG_SELECT_RST =
      FULL_ANALOG_SELECT ? sgp_pkg::ANALOG_SELECT_RST_FULL : sgp_pkg::ANALOG_SELECT_RST_SMALL;

   logic rst_all;
   sgp_pkg::sgp_req_s req;
   sgp_pkg::sgp_rsp_s rsp;
   logic [5:0] pin_s, pin_rd, an_mask, dig_mask, mism_v;
   logic [5:0] dir_q, pull_q, chgen_q, lat_q, last_q;
   logic [6:0] analog_select_q;
   logic gpull_dis_q, gie_q, flag_q, master_clear_enable_q;
   sgp_pkg::sgp_osc_e osc_q;
   logic xtal, wr0, port_acc, mism;
   logic [5:0] xt_fill, pu_d;
   logic [5:0] oe_q, pu_q, out_q;
   logic int_q, wake_q;
   sgp_pkg::sgp_adcclk_e adc_q;

   assign rst_all = RST | PWR_ON_RST;

   sgp_axil u_axil (
      .clk(CLK),
      .rst(rst_all),
      .awaddr(AWADDR),
      .awvalid(AWVALID),
      .awready(AWREADY),
      .wdata(WDATA),
      .wstrb(WSTRB),
      .wvalid(WVALID),
      .wready(WREADY),
      .bresp(BRESP),
      .bvalid(BVALID),
      .bready(BREADY),
      .araddr(ARADDR),
      .arvalid(ARVALID),
      .arready(ARREADY),
      .rdata(RDATA),
      .rresp(RRESP),
      .rvalid(RVALID),
      .rready(RREADY),
      .req(req),
      .rsp(rsp)
   );

   // Pins reach the read path and the comparator only after this.
   sgp_sync #(.W(sgp_pkg::NPIN)) u_sync (
      .clk(CLK),
      .rst(rst_all),
      .din(PIN_I),
      .dout(pin_s)
   );

   function automatic logic mapped(input logic [7:0] a);
      case (a)
         sgp_pkg::OFS_DATA, sgp_pkg::OFS_DIR, sgp_pkg::OFS_ANALOG_SELECT,
         sgp_pkg::OFS_PULL, sgp_pkg::OFS_CHGEN, sgp_pkg::OFS_OPT,
         sgp_pkg::OFS_INTC, sgp_pkg::OFS_CFG, sgp_pkg::OFS_DSET,
         sgp_pkg::OFS_DCLR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   function automatic sgp_pkg::sgp_adcclk_e adc_dec(input logic [2:0] c);
      case (c)
         3'h0: adc_dec = sgp_pkg::SGP_ADC_DIV2;
         3'h1: adc_dec = sgp_pkg::SGP_ADC_DIV8;
         3'h2: adc_dec = sgp_pkg::SGP_ADC_DIV32;
         3'h4: adc_dec = sgp_pkg::SGP_ADC_DIV4;
         3'h5: adc_dec = sgp_pkg::SGP_ADC_DIV16;
         3'h6: adc_dec = sgp_pkg::SGP_ADC_DIV64;
         default: adc_dec = sgp_pkg::SGP_ADC_RC;
      endcase
   endfunction : adc_dec

   assign xtal = (osc_q != sgp_pkg::SGP_OSC_OTHER);
   assign xt_fill = xtal ? sgp_pkg::XTAL_PINS : 6'h00;
   assign an_mask = {1'b0, analog_select_q[3], 1'b0, analog_select_q[2:0]};
   assign dig_mask = ~(xt_fill | (master_clear_enable_q ? sgp_pkg::MASTER_CLEAR_PIN : 6'h00));
   assign pin_rd = pin_s & ~an_mask & ~(master_clear_enable_q ? sgp_pkg::MASTER_CLEAR_PIN
                                                : 6'h00);
   assign mism_v = chgen_q & ~an_mask & dig_mask & (pin_s ^ last_q);
   assign mism = |mism_v;
   assign wr0 = req.wr & req.wstrb[0];
   assign port_acc = (req.rd & (req.raddr == sgp_pkg::OFS_DATA)) |
      (wr0 & ((req.waddr == sgp_pkg::OFS_DATA) |
              (req.waddr == sgp_pkg::OFS_DSET) |
              (req.waddr == sgp_pkg::OFS_DCLR)));

   always_comb begin
      rsp.rdata = 32'h0;
      rsp.rd_ok = mapped(req.raddr);
      rsp.wr_ok = mapped(req.waddr);
      case (req.raddr)
         sgp_pkg::OFS_DATA: rsp.rdata[5:0] = pin_rd;
         sgp_pkg::OFS_DIR: rsp.rdata[5:0] = dir_q | xt_fill;
         sgp_pkg::OFS_ANALOG_SELECT: rsp.rdata[6:0] = analog_select_q;
         sgp_pkg::OFS_PULL: rsp.rdata[5:0] = pull_q | xt_fill;
         sgp_pkg::OFS_CHGEN: rsp.rdata[5:0] = chgen_q | xt_fill;
         sgp_pkg::OFS_OPT: rsp.rdata[sgp_pkg::OPT_GPULL_BIT] = gpull_dis_q;
         sgp_pkg::OFS_INTC: begin
            rsp.rdata[sgp_pkg::INTC_GIE_BIT] = gie_q;
            rsp.rdata[sgp_pkg::INTC_FLAG_BIT] = flag_q;
         end
         sgp_pkg::OFS_CFG: begin
            rsp.rdata[sgp_pkg::CFG_MASTER_CLEAR_ENABLE_BIT] = master_clear_enable_q;
            rsp.rdata[sgp_pkg::CFG_OSC_LSB +: 2] = osc_q;
         end
         default: rsp.rdata = 32'h0;
      endcase
   end

   // Configuration registers written by software.
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         dir_q <= sgp_pkg::DIR_RST;
         pull_q <= sgp_pkg::PULL_RST;
         chgen_q <= sgp_pkg::CHGEN_RST;
         analog_select_q <= ANALOG_SELECT_RST;
         gpull_dis_q <= 1'b1;
         gie_q <= 1'b0;
         master_clear_enable_q <= 1'b0;
         osc_q <= sgp_pkg::SGP_OSC_OTHER;
      end else if (wr0) begin
         case (req.waddr)
            sgp_pkg::OFS_DIR:
               dir_q <= req.wdata[5:0] | sgp_pkg::DIR_FIXED;
            sgp_pkg::OFS_PULL:
               pull_q <= req.wdata[5:0] & sgp_pkg::PULL_MASK;
            sgp_pkg::OFS_CHGEN: chgen_q <= req.wdata[5:0];
            sgp_pkg::OFS_ANALOG_SELECT: analog_select_q <= req.wdata[6:0] & ANALOG_SELECT_MASK;
            sgp_pkg::OFS_OPT: gpull_dis_q <= req.wdata[sgp_pkg::OPT_GPULL_BIT];
            sgp_pkg::OFS_INTC: gie_q <= req.wdata[sgp_pkg::INTC_GIE_BIT];
            sgp_pkg::OFS_CFG: begin
               master_clear_enable_q <= req.wdata[sgp_pkg::CFG_MASTER_CLEAR_ENABLE_BIT];
               osc_q <= sgp_pkg::sgp_osc_e'(
                  req.wdata[sgp_pkg::CFG_OSC_LSB +: 2]);
            end
            default: dir_q <= dir_q;
         endcase
      end
   end

   // Output latch; set and clear aliases modify sampled pin levels.
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         lat_q <= sgp_pkg::LATCH_RST;
      end else if (wr0) begin
         case (req.waddr)
            sgp_pkg::OFS_DATA: lat_q <= req.wdata[5:0];
            sgp_pkg::OFS_DSET: lat_q <= pin_rd | req.wdata[5:0];
            sgp_pkg::OFS_DCLR: lat_q <= pin_rd & ~req.wdata[5:0];
            default: lat_q <= lat_q;
         endcase
      end
   end

   // The last-read latch is cleared by power-on reset only.
   always_ff @(posedge CLK) begin
      if (PWR_ON_RST) begin
         last_q <= sgp_pkg::LATCH_RST;
      end else if (port_acc) begin
         last_q <= pin_s;
      end
   end

   // Change flag: a mismatch wins over a software clear.
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         flag_q <= 1'b0;
      end else if (mism) begin
         flag_q <= 1'b1;
      end else if (wr0 && req.waddr == sgp_pkg::OFS_INTC) begin
         flag_q <= req.wdata[sgp_pkg::INTC_FLAG_BIT];
      end
   end

   always_comb begin
      pu_d = pull_q & dir_q & ~an_mask & ~xt_fill;
      if (gpull_dis_q) begin
         pu_d = 6'h00;
      end
      pu_d[3] = master_clear_enable_q;
   end

   // Pin drivers and status outputs.
   always_ff @(posedge CLK) begin
      if (rst_all) begin
         oe_q <= 6'h00;
         out_q <= sgp_pkg::LATCH_RST;
         pu_q <= 6'h00;
         int_q <= 1'b0;
         wake_q <= 1'b0;
         adc_q <= sgp_pkg::SGP_ADC_DIV2;
      end else begin
         oe_q <= ~dir_q & ~xt_fill & ~sgp_pkg::MASTER_CLEAR_PIN;
         out_q <= lat_q;
         pu_q <= pu_d;
         int_q <= flag_q & gie_q;
         wake_q <= flag_q;
         adc_q <= adc_dec(analog_select_q[sgp_pkg::ADCS_LSB +: 3]);
      end
   end

   assign PIN_OE = oe_q;
   assign PIN_O = out_q;
   assign PIN_PU = pu_q;
   assign INT_REQ = int_q;
   assign WAKE = wake_q;
   assign ADC_CLK = adc_q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (rst_all);

   property p_dir_drive;
      ##1 PIN_OE == $past(~dir_q & ~xt_fill & ~sgp_pkg::MASTER_CLEAR_PIN);
   endproperty
   a_dir_drive: assert property (p_dir_drive)
      else $error("Pin driver does not follow direction.");

   property p_pin3_in;
      !PIN_OE[3] && (dir_q[3] == 1'b1);
   endproperty
   a_pin3_in: assert property (p_pin3_in)
      else $error("Pin three is not input only.");

   property p_last_read;
      port_acc |=> last_q == $past(pin_s);
   endproperty
   a_last_read: assert property (p_last_read)
      else $error("Port access did not capture pin levels.");

   property p_master_clear_zero;
      master_clear_enable_q |-> !pin_rd[3];
   endproperty
   a_master_clear_zero: assert property (p_master_clear_zero)
      else $error("Pin three reads 1 under master clear.");

   property p_analog;
      (pin_rd & an_mask) == 6'h00 && (mism_v & an_mask) == 6'h00;
   endproperty
   a_analog: assert property (p_analog)
      else $error("Analog pin read or compared digitally.");

   localparam logic [5:0] MASTER_CLEAR_N = ~sgp_pkg::MASTER_CLEAR_PIN;
   property p_pu_off;
      ##1 (PIN_PU & MASTER_CLEAR_N & ($past(~dir_q) | $past(an_mask))) == 6'h00;
   endproperty
   a_pu_off: assert property (p_pu_off)
      else $error("Pull-up on with output or analog pin.");

   property p_global_pu;
      gpull_dis_q ##1 gpull_dis_q |-> (PIN_PU & MASTER_CLEAR_N) == 6'h00;
   endproperty
   a_global_pu: assert property (p_global_pu)
      else $error("Pull-up on while globally disabled.");

   property p_flag_set;
      mism |=> flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Mismatch did not set the change flag.");

   property p_flag_hold;
      (flag_q && mism) |=> flag_q;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("Flag cleared while mismatch persists.");

   property p_int_gie;
      INT_REQ |-> $past(gie_q) && $past(flag_q);
   endproperty
   a_int_gie: assert property (p_int_gie)
      else $error("Interrupt requested without global enable.");

   property p_wake;
      flag_q |=> WAKE;
   endproperty
   a_wake: assert property (p_wake)
      else $error("Set flag did not raise wake.");

   property p_xtal_read;
      (xtal && req.rd && req.raddr == sgp_pkg::OFS_DIR)
         |=> RDATA[5:4] == 2'h3;
   endproperty
   a_xtal_read: assert property (p_xtal_read)
      else $error("Direction bits 5:4 not 1 in crystal mode.");

   c_flag: cover property (mism ##1 flag_q ##[1:20] port_acc);
   c_int: cover property (gie_q && flag_q ##1 INT_REQ);
   c_rmw: cover property (wr0 && req.waddr == sgp_pkg::OFS_DSET);
endmodule : sgp_port

// ===== design/sgp_sync.sv
// Three-flop input synchroniser with agreement filter, one per bit.
// Assumes asynchronous inputs and a synchronous active-high reset.
`timescale 1ns/10ps
module sgp_sync #(
   parameter int W = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q, s2_q, s3_q, v_q;
         always_ff @(posedge clk) begin
            if (rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               v_q <= 1'b0;
            end else begin
               s1_q <= din[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  v_q <= s3_q;
               end
            end
         end
         assign dout[i] = v_q;
      end
   endgenerate
endmodule : sgp_sync

// ===== dv/sgp_pin_model.sv
// Pin model: resolves each pin from port drive, outside drive and pull-up.
// Assumes one clock; a pin left floating toggles every cycle.
`timescale 1ns/10ps
module sgp_pin_model (
   input wire logic clk,
   input wire logic [5:0] pin_o,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_pu,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   output logic [5:0] pin_i
);
   logic flt_q = 1'b0;
   always @(posedge clk) begin
      flt_q <= ~flt_q;
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_i[i] = pin_oe[i] ? pin_o[i] :
            ext_en[i] ? ext_val[i] : (pin_pu[i] | flt_q);
      end
   end
endmodule : sgp_pin_model

// ===== dv/sgp_tb.sv
// Self-checking bench for the six-pin port over AXI4-Lite.
// Assumes the pin model stands outside the port pins.
`timescale 1ns/10ps
module testbench;
   logic clk, rst, por, awv, wv, arv, bready, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awr, wr, bv, arr, rv, int_req, wake;
   logic [1:0] bresp, rresp;
   logic [5:0] pin_i, pin_o, pin_oe, pin_pu, ext_en, ext_val;
   sgp_pkg::sgp_adcclk_e adc_clk;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   sgp_port #(.FULL_ANALOG_SELECT(1'b1)) i_dut (.CLK(clk), .RST(rst),
      .PWR_ON_RST(por), .AWADDR(awaddr), .AWVALID(awv), .AWREADY(awr),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wv), .WREADY(wr),
      .BRESP(bresp), .BVALID(bv), .BREADY(bready), .ARADDR(araddr),
      .ARVALID(arv), .ARREADY(arr), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rv), .RREADY(rready), .PIN_I(pin_i), .PIN_O(pin_o),
      .PIN_OE(pin_oe), .PIN_PU(pin_pu), .INT_REQ(int_req), .WAKE(wake),
      .ADC_CLK(adc_clk));
   sgp_pin_model i_pins (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask : cy
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = sgp_pkg::RESP_OKAY);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv && n < 50);
      chk(n < 50, 1'b1);
      chk(bresp, r);
   endtask : axw
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r = sgp_pkg::RESP_OKAY);
      int n;
      n = 0;
      araddr <= a;
      arv <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arr) arv <= 1'b0;
      end while (!rv && n < 50);
      chk(rdata, e);
      chk(rresp, r);
   endtask : rdchk
   task automatic s_reset;
      rdchk(sgp_pkg::OFS_DIR, 32'h3F);
      rdchk(sgp_pkg::OFS_PULL, 32'h37);
      rdchk(sgp_pkg::OFS_CHGEN, 32'h00);
      rdchk(sgp_pkg::OFS_ANALOG_SELECT, 32'h0F);
      chk(pin_pu, 32'h00);
      axw(sgp_pkg::OFS_DIR, 32'hFF);
      rdchk(sgp_pkg::OFS_DIR, 32'h3F);
      wstrb <= 4'h0;
      axw(sgp_pkg::OFS_DIR, 32'h00);
      wstrb <= 4'hF;
      rdchk(sgp_pkg::OFS_DIR, 32'h3F);
      axw(8'h40, 32'h00, sgp_pkg::RESP_SLVERR);
      rdchk(8'h40, 32'h00, sgp_pkg::RESP_SLVERR);
   endtask : s_reset
   task automatic s_drive;
      ext_val <= 6'h00;
      axw(sgp_pkg::OFS_ANALOG_SELECT, 32'h01);
      axw(sgp_pkg::OFS_DATA, 32'h3F);
      axw(sgp_pkg::OFS_DIR, 32'h00);
      cy(6);
      chk(pin_oe, 32'h37);
      chk(pin_o & 6'h37, 32'h37);
      rdchk(sgp_pkg::OFS_DIR, 32'h08);
      rdchk(sgp_pkg::OFS_DATA, 32'h36);
      axw(sgp_pkg::OFS_DSET, 32'h00);
      cy(2);
      chk(pin_o & 6'h37, 32'h36);
      axw(sgp_pkg::OFS_DCLR, 32'h30);
      cy(2);
      chk(pin_o & 6'h37, 32'h06);
      ext_val <= 6'h3F;
      axw(sgp_pkg::OFS_ANALOG_SELECT, 32'h00);
   endtask : s_drive
   task automatic s_pull;
      axw(sgp_pkg::OFS_DIR, 32'h3F);
      axw(sgp_pkg::OFS_OPT, 32'h00);
      ext_en <= 6'h1F;
      cy(6);
      chk(pin_pu, 32'h37);
      rdchk(sgp_pkg::OFS_DATA, 32'h3F);
      axw(sgp_pkg::OFS_DIR, 32'h3E);
      cy(6);
      chk(pin_pu, 32'h36);
      axw(sgp_pkg::OFS_ANALOG_SELECT, 32'h08);
      cy(6);
      chk(pin_pu, 32'h26);
      rdchk(sgp_pkg::OFS_DATA, 32'h2E);
      axw(sgp_pkg::OFS_CFG, 32'h01);
      cy(6);
      chk(pin_pu, 32'h2E);
      rdchk(sgp_pkg::OFS_DATA, 32'h26);
      ext_en <= 6'h3F;
      axw(sgp_pkg::OFS_CFG, 32'h00);
      axw(sgp_pkg::OFS_DIR, 32'h3F);
      axw(sgp_pkg::OFS_ANALOG_SELECT, 32'h00);
   endtask : s_pull
   task automatic s_change;
      ext_val <= 6'h04;
      cy(6);
      rdchk(sgp_pkg::OFS_DATA, 32'h04);
      axw(sgp_pkg::OFS_CHGEN, 32'h04);
      axw(sgp_pkg::OFS_INTC, 32'h00);
      cy(2);
      chk(wake, 1'b0);
      ext_val <= 6'h00;
      cy(8);
      chk(wake, 1'b1);
      chk(int_req, 1'b0);
      axw(sgp_pkg::OFS_INTC, 32'h80);
      cy(3);
      chk(int_req, 1'b1);
      rdchk(sgp_pkg::OFS_INTC, 32'h81);
      rst <= 1'b1;
      cy(2);
      rst <= 1'b0;
      axw(sgp_pkg::OFS_CHGEN, 32'h04);
      axw(sgp_pkg::OFS_ANALOG_SELECT, 32'h00);
      cy(8);
      rdchk(sgp_pkg::OFS_INTC, 32'h01);
      rdchk(sgp_pkg::OFS_DATA, 32'h00);
      axw(sgp_pkg::OFS_INTC, 32'h00);
      cy(3);
      rdchk(sgp_pkg::OFS_INTC, 32'h00);
      axw(sgp_pkg::OFS_ANALOG_SELECT, 32'h04);
      ext_val <= 6'h04;
      cy(8);
      rdchk(sgp_pkg::OFS_INTC, 32'h00);
   endtask : s_change
   task automatic s_xtal;
      axw(sgp_pkg::OFS_DIR, 32'h0F);
      axw(sgp_pkg::OFS_PULL, 32'h00);
      for (int m = 1; m < 4; m++) begin
         axw(sgp_pkg::OFS_CFG, 32'(m << 1));
         rdchk(sgp_pkg::OFS_DIR, 32'h3F);
         rdchk(sgp_pkg::OFS_PULL, 32'h30);
         rdchk(sgp_pkg::OFS_CHGEN, 32'h34);
      end
      axw(sgp_pkg::OFS_CFG, 32'h00);
      rdchk(sgp_pkg::OFS_DIR, 32'h0F);
   endtask : s_xtal
   task automatic s_adc;
      sgp_pkg::sgp_adcclk_e e[8] = '{sgp_pkg::SGP_ADC_DIV2,
         sgp_pkg::SGP_ADC_DIV8, sgp_pkg::SGP_ADC_DIV32, sgp_pkg::SGP_ADC_RC,
         sgp_pkg::SGP_ADC_DIV4, sgp_pkg::SGP_ADC_DIV16,
         sgp_pkg::SGP_ADC_DIV64, sgp_pkg::SGP_ADC_RC};
      for (int c = 0; c < 8; c++) begin
         axw(sgp_pkg::OFS_ANALOG_SELECT, 32'(c << 4));
         cy(2);
         chk(adc_clk, e[c]);
         rdchk(sgp_pkg::OFS_ANALOG_SELECT, 32'(c << 4));
      end
   endtask : s_adc
   initial begin
      rst = 1'b1;
      por = 1'b1;
      awv = 1'b0;
      wv = 1'b0;
      arv = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      ext_en = 6'h3F;
      ext_val = 6'h3F;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      @(posedge clk);
      s_reset();
      s_drive();
      s_pull();
      s_change();
      s_xtal();
      s_adc();
      wrap_up();
   end
endmodule : testbench
